// ==== hw/rom_security_verify.sv ====
// ROM security lock, encrypted verify port and signature bytes
`timescale 1ns/1ps
`default_nettype none
`include "rom_security_verify_map.svh"
module rom_security_verify #(
    parameter bit LOCK_ENABLE = 1'b0,
    // Signature defaults are arbitrary values, not real maker codes
    parameter logic [7:0] SIG_MFR = 8'h5A,
    parameter logic [7:0] SIG_MODEL = 8'h3C,
    parameter logic [7:0] SIG_EXT = 8'h07,
    parameter int ROM_DEPTH = `RSV_ROM_DEPTH,
    parameter logic [8*`RSV_ENC_DEPTH-1:0] ENC_INIT = {`RSV_ENC_DEPTH{`RSV_ENC_BLANK}}
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Access pin
    input wire logic external_access_pin,
    // Verify port from programmer
    input wire rom_security_verify_pkg::verify_req_t verify_req,
    // Code table read from core
    input wire rom_security_verify_pkg::table_req_t table_req,
    // Results
    output logic [7:0] port0_out,
    output logic port0_oe,
    output logic [7:0] table_data,
    output logic table_valid,
    output logic ext_access_eff
);
    // ***********************************************
    // Storage
    // ***********************************************
    // Mask contents; zero unless preloaded from above
    logic [7:0] rom_mem [0:ROM_DEPTH-1];
    logic [7:0] enc_mem [0:`RSV_ENC_DEPTH-1];
    initial begin
        for (int i = 0; i < ROM_DEPTH; i++) begin
            rom_mem[i] = 8'h00;
        end
    end
    // Encryption array is constant, no write path exists
    always_comb begin
        for (int j = 0; j < `RSV_ENC_DEPTH; j++) begin
            enc_mem[j] = ENC_INIT[8*j +: 8];
        end
    end

    function automatic logic [7:0] rom_byte(input logic [15:0] a);
        rom_byte = rom_mem[int'(a) % ROM_DEPTH];
    endfunction

    // ***********************************************
    // State and helpers
    // ***********************************************
    rom_security_verify_pkg::mode_t mode_reg, mode_next;
    logic acc_reg, acc_next;
    logic [7:0] p0_reg, p0_next;
    logic p0oe_reg, p0oe_next;
    logic [7:0] td_reg, td_next;
    logic tv_reg, tv_next;
    logic [7:0] mem_byte;
    logic [7:0] enc_byte;

    // Unknown signature addresses read as zero
    function automatic logic [7:0] sig_byte(input logic [15:0] a);
        case (a)
            `RSV_SIG_MFR_ADDR: sig_byte = SIG_MFR;
            `RSV_SIG_MODEL_ADDR: sig_byte = SIG_MODEL;
            `RSV_SIG_EXT_ADDR: sig_byte = SIG_EXT;
            default: sig_byte = 8'h00;
        endcase
    endfunction

    // Bitwise XNOR of a byte with its mask
    function automatic logic [7:0] xnor_mask(input logic [7:0] d, input logic [7:0] m);
        xnor_mask = ~(d ^ m);
    endfunction

    // ***********************************************
    // Mode sequencing
    // ***********************************************
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            rom_security_verify_pkg::ST_RESET: begin
                mode_next = rom_security_verify_pkg::ST_RUN;
            end
            rom_security_verify_pkg::ST_RUN: begin
                if (verify_req.active) begin
                    mode_next = rom_security_verify_pkg::ST_VERIFY;
                end
            end
            rom_security_verify_pkg::ST_VERIFY: begin
                if (!verify_req.active) begin
                    mode_next = rom_security_verify_pkg::ST_RUN;
                end
            end
            default: begin
                mode_next = rom_security_verify_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= rom_security_verify_pkg::ST_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // ***********************************************
    // Access pin latch
    // ***********************************************
    // Locked parts ignore the pin once reset has ended
    always_comb begin
        acc_next = acc_reg;
        if (mode_reg == rom_security_verify_pkg::ST_RESET) begin
            acc_next = external_access_pin;
        end else if (!LOCK_ENABLE) begin
            acc_next = external_access_pin;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // ***********************************************
    // Verify port
    // ***********************************************
    always_comb begin
        mem_byte = rom_byte(verify_req.addr);
        enc_byte = enc_mem[verify_req.addr[`RSV_ENC_IDX_W-1:0]];
        p0oe_next = verify_req.active;
        p0_next = 8'h00;
        if (verify_req.active) begin
            if (verify_req.sig_sel) begin
                p0_next = sig_byte(verify_req.addr);
            end else begin
                // Blank FFh mask leaves the byte unchanged
                p0_next = xnor_mask(mem_byte, enc_byte);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            p0_reg <= 8'h00;
            p0oe_reg <= 1'b0;
        end else begin
            p0_reg <= p0_next;
            p0oe_reg <= p0oe_next;
        end
    end

    // ***********************************************
    // Code table reads
    // ***********************************************
    always_comb begin
        tv_next = table_req.valid;
        td_next = 8'h00;
        if (table_req.valid) begin
            // With the lock set, external table fetches return the blocked FFh byte instead of ROM data
            if (LOCK_ENABLE && table_req.fetch_external) begin
                td_next = `RSV_BLOCKED_BYTE;
            end else begin
                td_next = rom_byte(table_req.addr);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            td_reg <= 8'h00;
            tv_reg <= 1'b0;
        end else begin
            td_reg <= td_next;
            tv_reg <= tv_next;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    // Every output is a register, so no glitch reaches the pins
    assign port0_out = p0_reg;
    assign port0_oe = p0oe_reg;
    assign table_data = td_reg;
    assign table_valid = tv_reg;
    assign ext_access_eff = acc_reg;

endmodule
`default_nettype wire

// ==== hw/rom_security_verify_map.svh ====
// Constants for the ROM security and verify block
`ifndef ROM_SECURITY_VERIFY_MAP_SVH
`define ROM_SECURITY_VERIFY_MAP_SVH
`define RSV_ADDR_W 16
`define RSV_ROM_DEPTH 16384
`define RSV_ENC_DEPTH 64
`define RSV_ENC_IDX_W 6
`define RSV_SIG_MFR_ADDR 16'h0030
`define RSV_SIG_MODEL_ADDR 16'h0031
`define RSV_SIG_EXT_ADDR 16'h0060
`define RSV_ENC_BLANK 8'hFF
`define RSV_BLOCKED_BYTE 8'hFF
`endif

// ==== hw/rom_security_verify_pkg.sv ====
// Types for the ROM security and verify block
package rom_security_verify_pkg;
    typedef struct packed {
        logic active;
        logic sig_sel;
        logic [15:0] addr;
    } verify_req_t;
    typedef struct packed {
        logic fetch_external;
        logic [15:0] addr;
        logic valid;
    } table_req_t;
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_RUN = 3'b010,
        ST_VERIFY = 3'b100
    } mode_t;
endpackage

// ==== verification/prog_model.sv ====
// Programmer model presenting verify addresses
`timescale 1ns/1ps
`default_nettype none
module prog_model (input wire logic sys_clk, input wire logic go, input wire logic sig,
    input wire logic [15:0] a, output var rom_security_verify_pkg::verify_req_t req);
    initial req = '0;
    // Idle address inverted so nothing stale reads back
    always @(posedge sys_clk) req <= {go, go & sig, go ? a : ~req.addr};
endmodule
`default_nettype wire

// ==== verification/rom_security_verify_sva.sv ====
// Port assertions for the ROM security and verify block
`timescale 1ns/1ps
`default_nettype none
module rom_security_verify_sva #(parameter bit LOCK_ENABLE = 1'b0) (
    input wire logic sys_clk, input wire logic arst_n,
    input wire rom_security_verify_pkg::verify_req_t verify_req,
    input wire rom_security_verify_pkg::table_req_t table_req,
    input wire logic [7:0] port0_out, input wire logic [7:0] table_data,
    input wire logic port0_oe, input wire logic table_valid, input wire logic ext_access_eff);
    logic up_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) up_reg <= 1'b0;
        else up_reg <= 1'b1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    chk_oe_rise: assert property (verify_req.active |=> port0_oe) else $error("oe");
    chk_oe_fall: assert property (!verify_req.active |=> !port0_oe) else $error("oe");
    chk_tv_rise: assert property (table_req.valid |=> table_valid) else $error("tv");
    chk_tv_fall: assert property (!table_req.valid |=> !table_valid) else $error("tv");
    chk_table_block: assert property (LOCK_ENABLE && table_req.valid
        && table_req.fetch_external |=> table_data == 8'hFF) else $error("leak");
    chk_acc_hold: assert property (LOCK_ENABLE && up_reg |=> $stable(ext_access_eff))
        else $error("access latch moved");
    chk_sig_other: assert property (verify_req.active && verify_req.sig_sel
        && verify_req.addr == 16'h0040 |=> port0_out == 8'h00) else $error("sig");
    chk_p0_hold: assert property (up_reg && verify_req.active && $stable(verify_req)
        |=> $stable(port0_out)) else $error("p0");
    cover property (verify_req.active && verify_req.sig_sel);
    cover property (verify_req.active && !verify_req.sig_sel);
    cover property (table_req.valid && table_req.fetch_external);
endmodule
bind rom_security_verify rom_security_verify_sva #(.LOCK_ENABLE(LOCK_ENABLE)) u_sva (
    .sys_clk(sys_clk), .arst_n(arst_n), .verify_req(verify_req), .table_req(table_req),
    .port0_out(port0_out), .table_data(table_data), .port0_oe(port0_oe),
    .table_valid(table_valid), .ext_access_eff(ext_access_eff));
`default_nettype wire

// ==== verification/rom_security_verify_tb.sv ====
// Self-checking bench for the ROM security and verify block
`timescale 1ns/1ps
`default_nettype none
module rom_security_verify_tb;
    logic sys_clk = 1'b0;
    logic arst_n, pin, go, sig, oe, tv, acc;
    logic [15:0] a;
    logic [7:0] p0, td;
    rom_security_verify_pkg::verify_req_t vq;
    rom_security_verify_pkg::table_req_t tq;
    int err_total = 0;
    int tests_run = 0;
    // Select, address, port0 byte; ROM reads as zero
    logic [24:0] rows [6] = '{{1'b0, 16'h0045, 8'h5A}, {1'b0, 16'h0025, 8'h00},
        {1'b1, 16'h0030, 8'h11}, {1'b1, 16'h0060, 8'h33}, {1'b1, 16'h0040, 8'h00},
        {1'b1, 16'h0031, 8'h22}};
    prog_model u_prog_model (.sys_clk(sys_clk), .go(go), .sig(sig), .a(a), .req(vq));
    // Signature values are arbitrary
    rom_security_verify #(.LOCK_ENABLE(1'b1), .SIG_MFR(8'h11), .SIG_MODEL(8'h22), .SIG_EXT(8'h33),
        .ENC_INIT({{32{8'hFF}}, {32{8'hA5}}})) u_rom_security_verify (
        .sys_clk(sys_clk), .arst_n(arst_n), .external_access_pin(pin), .verify_req(vq),
        .table_req(tq), .port0_out(p0), .port0_oe(oe), .table_data(td), .table_valid(tv),
        .ext_access_eff(acc));
    task automatic chk(input logic [7:0] s, input logic [7:0] e, input string n);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        repeat (1000) @(posedge sys_clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {arst_n, go, sig, a, tq} = '0;
        pin = 1'b1;
        repeat (10) @(posedge sys_clk);
        chk({6'h00, oe, tv}, 8'h00, "reset");
        arst_n <= 1'b1;
        @(posedge sys_clk);
        pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h00, acc}, 8'h01, "access");
        foreach (rows[i]) begin
            @(posedge sys_clk);
            {go, sig, a} <= {1'b1, rows[i][24:8]};
            repeat (3) @(posedge sys_clk);
            #1 chk(p0, rows[i][7:0], "verify");
            chk({7'h00, oe}, 8'h01, "oe");
        end
        @(posedge sys_clk);
        {go, tq} <= {1'b0, 1'b1, 16'h0100, 1'b1};
        @(posedge sys_clk);
        tq <= {1'b0, 16'h0100, 1'b1};
        #1 chk(td, 8'hFF, "blocked");
        @(posedge sys_clk);
        tq <= '0;
        #1 chk(td, 8'h00, "internal");
        chk({7'h00, tv}, 8'h01, "tvalid");
        arst_n <= 1'b0;
        @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        pin <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h00, acc}, 8'h00, "relatch");
        chk({7'h00, tv}, 8'h00, "tidle");
        tally_and_finish();
    end
endmodule
`default_nettype wire
